// *** hdl/lps_consts.svh ***
// named constants for the log sense handler
`ifndef LPS_CONSTS_SVH
`define LPS_CONSTS_SVH
`define OPC_LOG_SENSE 8'h4D
`define ST_GOOD 8'h00
`define ST_CHECK 8'h02
`define SK_NONE 8'h00
`define SK_ILLEGAL 8'h05
`define ASC_NONE 8'h00
`define ASC_BAD_CDB 8'h24
`define ASC_BAD_OPC 8'h20
`define PG_LIST 6'h00
`define PG_WRITE 6'h02
`define PG_READ 6'h03
`define PG_VERIFY 6'h05
`define PG_NONMED 6'h06
`define PG_HOURS 6'h08
`define LIST_LEN 16'h0006
`define HDR_BYTES 16'h0004
`define PRM_LEN 8'h04
`define CODE_OTF 3'h0
`define CODE_ECC 3'h1
`define CODE_OTHER 3'h2
`define CODE_SUM 3'h3
`define CODE_TIMES 3'h4
`define CODE_BYTES 3'h5
`define CODE_UNC 3'h6
`define KIND_OTF 2'h0
`define KIND_UNC 2'h3
`define ROW_W 2'h0
`define ROW_R 2'h1
`define ROW_V 2'h2
`define ROW_NONE 2'h3
`define THR_DEFAULT 32'hFFFFFFFF
`define CUM_DEFAULT 32'h00000000
`define PC_THR 2'h0
`define PC_CUM 2'h1
`define PC_DTHR 2'h2
`define B_OP 0
`define B_FLAGS 1
`define B_PAGE 2
`define B_PTR 5
`define B_ALLOC 7
`define BIT_SP 0
`define BIT_PPC 1
`define PCB_DU 7
`define PCB_LP 0
`define CTL_START 0
`define CTL_RESET 1
`define A_CDB0 8'h00
`define A_CDB1 8'h04
`define A_CDB2 8'h08
`define A_CTRL 8'h0C
`define A_STAT 8'h10
`define A_SENT 8'h14
`endif

// *** hdl/lps_pkg.sv ***
// shared types for the log sense handler
package lps_pkg;
  typedef enum logic [1:0] {S_IDLE, S_CHECK, S_SEND, S_DONE} state_t;
endpackage

// *** hdl/log_page_sense_handler.sv ***
// log sense command handler with wishbone register access
//
// The register offsets and the Wishbone interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
`include "lps_consts.svh"
// How it works
// - page code map: list, standard, reserved, vendor
// - only pages 0,2,3,5,6,8 implemented
// - page 8 holds power-on hours, code 0
// - error pages carry codes 0 (1 on write) to 6
// - write page holds codes 1 to 6
// - read and verify pages hold codes 0-6
// - page 6 holds non-medium error count
// - code 0 counts on-the-fly fixes, not write
// - code 1 counts ecc or write-fault retry
// - code 2 counts other recoveries
// - code 3 is the sum of recoveries
// - code 4 counts correction or retry uses
// - code 5 accumulates bytes moved
// - control byte honoured, list bit unsupported
// - ten byte descriptor, opcode 4Dh decoded
// - bad page code gives invalid field check
// - save bit set is rejected, no saving
// - saving absent, so nothing stored
// - changed-only reporting not offered
// - ascending codes from pointer, allocation limited
// - pointer above largest code is rejected
// - last update reported, else defaults
// - page control bits select value set
// - pc 0 thr, 1 cum, 2/3 defaults
module log_page_sense_handler (
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic err_evt_i,
  input wire logic [1:0] err_page_i,
  input wire logic [1:0] err_kind_i,
  input wire logic retry_evt_i,
  input wire logic bytes_evt_i,
  input wire logic [15:0] bytes_n_i,
  input wire logic nonmed_evt_i,
  input wire logic hour_tick_i,
  output logic [7:0] data_o,
  output logic data_valid_o,
  input wire logic data_ready_i,
  output logic busy_o
);

  logic [7:0] cdb_ff [0:9];
  logic [31:0] cnt_ff [0:2][0:6];
  logic [31:0] nonmed_ff;
  logic [31:0] hours_ff;
  logic upd_ff;
  logic [7:0] pcb_ff;
  logic start_ff;
  logic devrst_ff;
  logic ack_ff;
  logic [31:0] dat_ff;
  logic [31:0] nxt_dat;
  lps_pkg::state_t state_ff;
  lps_pkg::state_t nxt_state;
  logic [7:0] status_ff;
  logic [7:0] sense_ff;
  logic [7:0] asc_ff;
  logic done_ff;
  logic [15:0] idx_ff;
  logic [15:0] nxt_idx;
  logic [15:0] limit_ff;
  logic [15:0] total_ff;
  logic [15:0] sent_ff;
  logic [2:0] first_ff;
  logic [7:0] data_ff;
  logic [7:0] nxt_data;
  logic wb_req;
  logic wb_wr;
  logic busy;
  logic hs;
  logic [7:0] opc;
  logic sp_bit;
  logic ppc_bit;
  logic [1:0] pcf;
  logic [5:0] page;
  logic [15:0] ptr;
  logic [15:0] alloc;
  logic ptr_high;
  logic bad_field;
  logic [2:0] first;
  logic [3:0] nparams;
  logic [15:0] total;
  logic [15:0] k;
  logic [2:0] pcode;
  logic [15:0] plen;
  logic [31:0] cum;
  logic [31:0] val;
  logic [1:0] row;
  logic [2:0] evt_code;

  function automatic logic page_ok(input logic [5:0] p);
    page_ok = (p == `PG_LIST) || (p == `PG_WRITE) || (p == `PG_READ) ||
              (p == `PG_VERIFY) || (p == `PG_NONMED) || (p == `PG_HOURS);
  endfunction

  // write page starts at code 1
  function automatic logic [2:0] code_min(input logic [5:0] p);
    code_min = (p == `PG_WRITE) ? `CODE_ECC : `CODE_OTF;
  endfunction

  // read and verify end at 6
  function automatic logic [2:0] code_max(input logic [5:0] p);
    code_max = (p == `PG_WRITE || p == `PG_READ || p == `PG_VERIFY) ? `CODE_UNC : `CODE_OTF;
  endfunction

  function automatic logic [1:0] page_row(input logic [5:0] p);
    page_row = (p == `PG_WRITE) ? `ROW_W : (p == `PG_READ) ? `ROW_R :
               (p == `PG_VERIFY) ? `ROW_V : `ROW_NONE;
  endfunction

  function automatic logic [7:0] list_entry(input logic [2:0] n);
    unique case (n)
      3'h0: list_entry = {2'h0, `PG_LIST};
      3'h1: list_entry = {2'h0, `PG_WRITE};
      3'h2: list_entry = {2'h0, `PG_READ};
      3'h3: list_entry = {2'h0, `PG_VERIFY};
      3'h4: list_entry = {2'h0, `PG_NONMED};
      3'h5: list_entry = {2'h0, `PG_HOURS};
      default: list_entry = 8'h00;
    endcase
  endfunction

  assign opc = cdb_ff[`B_OP];
  assign sp_bit = cdb_ff[`B_FLAGS][`BIT_SP];
  assign ppc_bit = cdb_ff[`B_FLAGS][`BIT_PPC];
  assign pcf = cdb_ff[`B_PAGE][7:6];
  assign page = cdb_ff[`B_PAGE][5:0];
  assign ptr = {cdb_ff[`B_PTR], cdb_ff[`B_PTR + 1]};
  assign alloc = {cdb_ff[`B_ALLOC], cdb_ff[`B_ALLOC + 1]};

  assign busy = (state_ff != lps_pkg::S_IDLE);
  assign busy_o = busy;
  assign wb_req = wb_cyc_i && wb_stb_i && !ack_ff;
  // writes land on the ack edge, while the master still holds the request
  assign wb_wr = wb_cyc_i && wb_stb_i && wb_we_i && ack_ff;
  assign wb_ack_o = ack_ff;
  assign wb_dat_o = dat_ff;
  assign data_valid_o = (state_ff == lps_pkg::S_SEND);
  assign data_o = data_ff;
  assign hs = data_valid_o && data_ready_i;

  assign ptr_high = ptr > {13'h0000, code_max(page)};
  // save bit has no saving store behind it
  // no non-volatile store, so sp is refused
  assign bad_field = !page_ok(page) || sp_bit || ppc_bit || ptr_high;
  // start at pointer or page's first code
  assign first = (ptr < {13'h0000, code_min(page)}) ? code_min(page) : ptr[2:0];
  assign nparams = {1'b0, code_max(page)} - {1'b0, first} + 4'h1;
  // eight bytes per parameter: code, control, length, four value bytes
  assign total = (page == `PG_LIST) ? `HDR_BYTES + `LIST_LEN :
                 `HDR_BYTES + {9'h000, nparams, 3'h0};

  // wishbone slave, one wait state per access
  always_ff @(posedge core_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      ack_ff <= 1'b0;
    else
      ack_ff <= wb_req;
  end

  always_comb
  begin
    unique case (wb_adr_i)
      `A_CDB0: nxt_dat = {cdb_ff[3], cdb_ff[2], cdb_ff[1], cdb_ff[0]};
      `A_CDB1: nxt_dat = {cdb_ff[7], cdb_ff[6], cdb_ff[5], cdb_ff[4]};
      `A_CDB2: nxt_dat = {16'h0000, cdb_ff[9], cdb_ff[8]};
      `A_CTRL: nxt_dat = {16'h0000, pcb_ff, 8'h00};
      `A_STAT: nxt_dat = {6'h00, done_ff, busy, asc_ff, sense_ff, status_ff};
      `A_SENT: nxt_dat = {16'h0000, sent_ff};
      default: nxt_dat = 32'h00000000;
    endcase
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      dat_ff <= 32'h00000000;
    else if (wb_req && !wb_we_i)
      dat_ff <= nxt_dat;
  end

  // descriptor is frozen while a command runs, so decode stays coherent
  always_ff @(posedge core_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      for (int i = 0; i < 10; i++)
        cdb_ff[i] <= 8'h00;
      pcb_ff <= 8'h00;
      start_ff <= 1'b0;
      devrst_ff <= 1'b0;
    end
    else
    begin
      start_ff <= 1'b0;
      devrst_ff <= 1'b0;
      if (wb_wr && !busy)
      begin
        for (int b = 0; b < 4; b++)
          if (wb_sel_i[b])
          begin
            if (wb_adr_i == `A_CDB0)
              cdb_ff[b] <= wb_dat_i[8*b +: 8];
            if (wb_adr_i == `A_CDB1)
              cdb_ff[4+b] <= wb_dat_i[8*b +: 8];
            if (wb_adr_i == `A_CDB2 && b < 2)
              cdb_ff[8+b] <= wb_dat_i[8*b +: 8];
          end
        if (wb_adr_i == `A_CTRL && wb_sel_i[0])
        begin
          start_ff <= wb_dat_i[`CTL_START];
          devrst_ff <= wb_dat_i[`CTL_RESET];
        end
        if (wb_adr_i == `A_CTRL && wb_sel_i[1])
          pcb_ff <= wb_dat_i[15:8] & ~(8'h01 << `PCB_LP);
      end
    end
  end

  // kinds 0..2 map straight onto codes 0..2, kind 3 onto code 6
  assign evt_code = (err_kind_i == `KIND_UNC) ? `CODE_UNC : {1'b0, err_kind_i};

  // event counters; a device reset returns them to defaults
  always_ff @(posedge core_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      for (int r = 0; r < 3; r++)
        for (int c = 0; c < 7; c++)
          cnt_ff[r][c] <= `CUM_DEFAULT;
      nonmed_ff <= `CUM_DEFAULT;
      hours_ff <= `CUM_DEFAULT;
      upd_ff <= 1'b0;
    end
    else if (devrst_ff)
    begin
      for (int r = 0; r < 3; r++)
        for (int c = 0; c < 7; c++)
          cnt_ff[r][c] <= `CUM_DEFAULT;
      nonmed_ff <= `CUM_DEFAULT;
      hours_ff <= `CUM_DEFAULT;
      upd_ff <= 1'b0;
    end
    else if (!pcb_ff[`PCB_DU])
    begin
      // count error events by kind, except on-the-fly on the write page
      if (err_evt_i && err_page_i != `ROW_NONE &&
          !(err_page_i == `ROW_W && err_kind_i == `KIND_OTF))
        cnt_ff[err_page_i][evt_code] <= cnt_ff[err_page_i][evt_code] + 32'h00000001;
      if (retry_evt_i && err_page_i != `ROW_NONE)
        cnt_ff[err_page_i][`CODE_TIMES] <= cnt_ff[err_page_i][`CODE_TIMES] + 32'h00000001;
      if (bytes_evt_i && err_page_i != `ROW_NONE)
        cnt_ff[err_page_i][`CODE_BYTES] <= cnt_ff[err_page_i][`CODE_BYTES] +
                                            {16'h0000, bytes_n_i};
      if (nonmed_evt_i)
        nonmed_ff <= nonmed_ff + 32'h00000001;
      if (hour_tick_i)
        hours_ff <= hours_ff + 32'h00000001;
      if (err_evt_i || retry_evt_i || bytes_evt_i || nonmed_evt_i || hour_tick_i)
        upd_ff <= 1'b1;
    end
  end

  // command sequencer
  always_comb
  begin
    nxt_state = state_ff;
    unique case (state_ff)
      lps_pkg::S_IDLE:
        if (start_ff)
          nxt_state = lps_pkg::S_CHECK;
      lps_pkg::S_CHECK:
        if (opc != `OPC_LOG_SENSE || bad_field || alloc == 16'h0000)
          nxt_state = lps_pkg::S_DONE;
        else
          nxt_state = lps_pkg::S_SEND;
      lps_pkg::S_SEND:
        if (hs && idx_ff + 16'h0001 == limit_ff)
          nxt_state = lps_pkg::S_DONE;
      lps_pkg::S_DONE:
        nxt_state = lps_pkg::S_IDLE;
    endcase
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      state_ff <= lps_pkg::S_IDLE;
      status_ff <= `ST_GOOD;
      sense_ff <= `SK_NONE;
      asc_ff <= `ASC_NONE;
      done_ff <= 1'b0;
    end
    else
    begin
      state_ff <= nxt_state;
      if (start_ff && state_ff == lps_pkg::S_IDLE)
      begin
        done_ff <= 1'b0;
        status_ff <= `ST_GOOD;
        sense_ff <= `SK_NONE;
        asc_ff <= `ASC_NONE;
      end
      if (state_ff == lps_pkg::S_CHECK)
      begin
        // only the log sense opcode is served
        if (opc != `OPC_LOG_SENSE)
        begin
          status_ff <= `ST_CHECK;
          sense_ff <= `SK_ILLEGAL;
          asc_ff <= `ASC_BAD_OPC;
        end
        else if (bad_field)
        begin
          status_ff <= `ST_CHECK;
          sense_ff <= `SK_ILLEGAL;
          asc_ff <= `ASC_BAD_CDB;
        end
      end
      if (nxt_state == lps_pkg::S_DONE && state_ff != lps_pkg::S_DONE)
        done_ff <= 1'b1;
    end
  end

  // transfer bookkeeping
  always_ff @(posedge core_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      limit_ff <= 16'h0000;
      total_ff <= 16'h0000;
      first_ff <= 3'h0;
      sent_ff <= 16'h0000;
    end
    else if (state_ff == lps_pkg::S_CHECK)
    begin
      limit_ff <= (alloc < total) ? alloc : total;
      total_ff <= total;
      first_ff <= first;
      sent_ff <= 16'h0000;
    end
    else if (hs)
      sent_ff <= sent_ff + 16'h0001;
  end

  always_comb
  begin
    nxt_idx = idx_ff;
    if (state_ff == lps_pkg::S_CHECK)
      nxt_idx = 16'h0000;
    else if (hs)
      nxt_idx = idx_ff + 16'h0001;
  end

  // parameters walk upward from the first code
  assign k = nxt_idx - `HDR_BYTES;
  assign pcode = first_ff + k[5:3];
  assign plen = total_ff - `HDR_BYTES;
  assign row = page_row(page);

  // sum code is built, never stored
  // before any update, defaults are reported
  always_comb
  begin
    cum = `CUM_DEFAULT;
    if (page == `PG_NONMED)
      cum = nonmed_ff;
    else if (page == `PG_HOURS)
      cum = hours_ff;
    else if (row == `ROW_NONE)
      cum = `CUM_DEFAULT;
    else if (pcode == `CODE_SUM)
      cum = cnt_ff[row][`CODE_ECC] + cnt_ff[row][`CODE_OTHER] +
            ((row == `ROW_W) ? `CUM_DEFAULT : cnt_ff[row][`CODE_OTF]);
    else if (pcode <= `CODE_UNC)
      cum = cnt_ff[row][pcode];
    // page control picks the value set
    // thresholds default to all ones, cumulative to zero
    unique case (pcf)
      `PC_THR: val = `THR_DEFAULT;
      `PC_CUM: val = upd_ff ? cum : `CUM_DEFAULT;
      `PC_DTHR: val = `THR_DEFAULT;
      default: val = `CUM_DEFAULT;
    endcase
  end

  // error pages laid out code by code
  always_comb
  begin
    nxt_data = 8'h00;
    if (nxt_idx == 16'h0000)
      nxt_data = {2'h0, page};
    else if (nxt_idx == 16'h0002)
      nxt_data = plen[15:8];
    else if (nxt_idx == 16'h0003)
      nxt_data = plen[7:0];
    else if (nxt_idx < `HDR_BYTES)
      nxt_data = 8'h00;
    else if (page == `PG_LIST)
      nxt_data = list_entry(k[2:0]);
    else
      unique case (k[2:0])
        3'h0: nxt_data = 8'h00;
        3'h1: nxt_data = {5'h00, pcode};
        // control byte as set by software, with the LP bit cleared
        3'h2: nxt_data = pcb_ff;
        3'h3: nxt_data = `PRM_LEN;
        3'h4: nxt_data = val[31:24];
        3'h5: nxt_data = val[23:16];
        3'h6: nxt_data = val[15:8];
        3'h7: nxt_data = val[7:0];
      endcase
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      idx_ff <= 16'h0000;
      data_ff <= 8'h00;
    end
    else
    begin
      idx_ff <= nxt_idx;
      data_ff <= nxt_data;
    end
  end

  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (!rst_n_i);

  sequence s_chk_ok;
    state_ff == lps_pkg::S_CHECK && opc == `OPC_LOG_SENSE;
  endsequence

  sequence s_rej;
    ##1 state_ff == lps_pkg::S_DONE && status_ff == `ST_CHECK &&
      sense_ff == `SK_ILLEGAL && asc_ff == `ASC_BAD_CDB;
  endsequence

  AST_BAD_PAGE: assert property (s_chk_ok ##0 !page_ok(page) |-> s_rej)
    else $error("unimplemented page not rejected");
  AST_SP_SET: assert property (s_chk_ok ##0 sp_bit |-> s_rej)
    else $error("save bit not rejected");
  AST_PPC_SET: assert property (s_chk_ok ##0 ppc_bit |-> s_rej)
    else $error("ppc bit not rejected");
  AST_PTR_HIGH: assert property (s_chk_ok ##0 ptr_high |-> s_rej)
    else $error("pointer above largest code not rejected");
  AST_FIRST_BYTE: assert property (s_chk_ok ##0 (!bad_field && alloc != 16'h0000) |=>
    state_ff == lps_pkg::S_SEND && data_o == {2'h0, page})
    else $error("response does not open with page code");
  AST_ASCEND: assert property (hs && idx_ff + 16'h0001 < limit_ff |=>
    data_valid_o && idx_ff == $past(idx_ff) + 16'h0001)
    else $error("byte index did not advance by one");
  AST_LIMIT: assert property (data_valid_o |-> idx_ff < limit_ff && limit_ff <= alloc)
    else $error("transfer exceeds allocation length");
  AST_WR_OTF: assert property (err_evt_i && err_page_i == `ROW_W &&
    err_kind_i == `KIND_OTF && !devrst_ff |=> $stable(cnt_ff[0][0]))
    else $error("write page on-the-fly counter moved");
  AST_RD_OTF: assert property (err_evt_i && err_page_i == `ROW_R && err_kind_i == `KIND_OTF &&
    !devrst_ff && !pcb_ff[`PCB_DU] |=> cnt_ff[1][0] == $past(cnt_ff[1][0]) + 32'h00000001)
    else $error("read on-the-fly counter missed an event");
  AST_DU_HOLD: assert property (pcb_ff[`PCB_DU] && hour_tick_i && !devrst_ff |=>
    hours_ff == $past(hours_ff))
    else $error("counter updated while update disabled");

endmodule // log_page_sense_handler

// *** bench/lps_sink.sv ***
// initiator-side byte sink for the response stream
`timescale 1ns/1ps
module lps_sink (
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic slow_i,
  input wire logic data_valid_i,
  input wire logic [7:0] data_i,
  output logic ready_o
);
  logic [7:0] got[$];
  // with slow_i set, random stalls stretch byte handshakes, as a busy host would
  always @(posedge core_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      ready_o <= 1'b0;
    end
    else
    begin
      if (data_valid_i && ready_o)
        got.push_back(data_i);
      ready_o <= slow_i ? 1'($urandom_range(1)) : 1'b1;
    end
  end
endmodule // lps_sink

// *** bench/tb.sv ***
// self-checking bench for the log sense handler
`timescale 1ns/1ps
module tb;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic cyc = 1'b0, stb = 1'b0, we = 1'b0, ack, dv, rdy, busy, slow = 1'b0;
  logic [7:0] adr = 8'h00, dout;
  logic [31:0] wdat = 32'h0, rdat, r;
  logic ev = 1'b0, rt = 1'b0, bt = 1'b0, nm = 1'b0, hr = 1'b0;
  logic [1:0] epg = 2'h0, ekd = 2'h0;
  logic [15:0] bn = 16'h0000;
  int err_total = 0, tests_run = 0;
  int cnt[3][7];
  int nmc, hrc, upd, frz = 0;
  // page list reply: header, then the supported codes
  int dut_pages[10] = '{0, 0, 0, 6, 0, 2, 3, 5, 6, 8};
  logic [7:0] exp_q[$];

  always #20 clk = ~clk;

  log_page_sense_handler dut (.core_clk_i(clk), .rst_n_i(rst_n), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat),
    .wb_dat_o(rdat), .wb_ack_o(ack), .err_evt_i(ev), .err_page_i(epg), .err_kind_i(ekd),
    .retry_evt_i(rt), .bytes_evt_i(bt), .bytes_n_i(bn), .nonmed_evt_i(nm),
    .hour_tick_i(hr), .data_o(dout), .data_valid_o(dv), .data_ready_i(rdy), .busy_o(busy));

  lps_sink u_sink (.core_clk_i(clk), .rst_n_i(rst_n), .slow_i(slow), .data_valid_i(dv),
    .data_i(dout), .ready_o(rdy));

  task automatic conclude();
    $display("comparisons %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      err_total++;
      $display("wrong value at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // one classic cycle, held until ack is sampled high
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    i = 0;
    do
    begin
      @(posedge clk);
      i++;
    end
    while (ack !== 1'b1 && i < 50);
    r = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    if (i >= 50)
    begin
      err_total++;
      conclude();
    end
  endtask

  function automatic int val(int pg, int pc, int c);
    int w;
    if (pc == 0 || pc == 2)
      return 32'hFFFFFFFF;
    if (pc == 3 || upd == 0)
      return 0;
    if (pg == 6)
      return nmc;
    if (pg == 8)
      return hrc;
    w = (pg == 2) ? 0 : (pg == 3) ? 1 : 2;
    if (c == 3)
      return (w == 0 ? 0 : cnt[w][0]) + cnt[w][1] + cnt[w][2];
    return cnt[w][c];
  endfunction

  task automatic push(input int b);
    exp_q.push_back(b[7:0]);
  endtask

  task automatic cmd(input logic [7:0] op, input logic [7:0] fl, input logic [7:0] pb,
                     input logic [15:0] ptr, input logic [15:0] al);
    int pg, mn, mx, s, ln, v, i;
    logic [23:0] st;
    pg = pb[5:0];
    mn = (pg == 2) ? 1 : 0;
    mx = (pg == 2 || pg == 3 || pg == 5) ? 6 : 0;
    exp_q.delete();
    if (op != 8'h4D)
      st = 24'h200502;
    else if (!(pg inside {0, 2, 3, 5, 6, 8}) || fl[0] || fl[1] || ptr > mx)
      st = 24'h240502;
    else
    begin
      st = 24'h000000;
      if (pg == 0)
        foreach (dut_pages[j]) push(dut_pages[j]);
      else
      begin
        s = (ptr < mn) ? mn : ptr;
        ln = (mx - s + 1) * 8;
        push(pg);
        push(0);
        push(ln >> 8);
        push(ln);
        for (int c = s; c <= mx; c++)
        begin
          v = val(pg, pb[7:6], c);
          push(0);
          push(c);
          push(8'h04);
          push(4);
          for (int k = 3; k >= 0; k--) push(v >> (8 * k));
        end
      end
      while (exp_q.size() > al) void'(exp_q.pop_back());
    end
    u_sink.got.delete();
    wb(1'b1, 8'h00, {8'h00, pb, fl, op});
    wb(1'b1, 8'h04, {al[15:8], ptr[7:0], ptr[15:8], 8'h00});
    wb(1'b1, 8'h08, {16'h0, 8'h00, al[7:0]});
    wb(1'b1, 8'h0C, {16'h0, 8'h05, 8'h01});
    repeat (2) @(negedge clk);
    chk(busy, 1'b1);
    i = 0;
    do
    begin
      wb(1'b0, 8'h10, 32'h0);
      i++;
    end
    while (!(r[25] === 1'b1 && r[24] === 1'b0) && i < 3000);
    if (i >= 3000)
    begin
      err_total++;
      conclude();
    end
    chk(r[23:0], st);
    chk(u_sink.got.size(), exp_q.size());
    foreach (exp_q[j]) chk(u_sink.got[j], exp_q[j]);
    wb(1'b0, 8'h14, 32'h0);
    chk(r, exp_q.size());
  endtask

  task automatic events(input int n);
    int p, k, e, t, b, m, h, x;
    repeat (n)
    begin
      @(posedge clk);
      p = $urandom_range(3);
      k = $urandom_range(3);
      {e, t, b, m, h} = {$urandom_range(1), $urandom_range(1), $urandom_range(1),
                         $urandom_range(1), $urandom_range(1)};
      x = $urandom_range(16'hFFFF);
      ev <= e;
      rt <= t;
      bt <= b;
      nm <= m;
      hr <= h;
      epg <= p;
      ekd <= k;
      bn <= x;
      // frozen counters leave the model untouched
      if (!frz)
      begin
        // write page has no on-the-fly counter
        if (p < 3 && e && !(p == 0 && k == 0))
          cnt[p][k == 3 ? 6 : k]++;
        if (p < 3 && t)
          cnt[p][4]++;
        if (p < 3 && b)
          cnt[p][5] += x;
        nmc += m;
        hrc += h;
        upd = 1;
      end
    end
    @(posedge clk);
    {ev, rt, bt, nm, hr} <= 5'h00;
  endtask

  initial
  begin
    void'($urandom(32'h1A47));
    nmc = 0;
    hrc = 0;
    upd = 0;
    foreach (cnt[a, b]) cnt[a][b] = 0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    wb(1'b0, 8'h18, 32'h0);
    chk(r, 32'h0);
    cmd(8'h4D, 8'h00, 8'h43, 16'h0, 16'hFFFF);
    events(300);
    slow <= 1'b1;
    // every page code with pc 1, every value set on implemented pages
    for (int pg = 0; pg < 64; pg++)
      for (int pc = 0; pc < 4; pc++)
        if (pc == 1 || pg inside {0, 2, 3, 5, 6, 8})
          cmd(8'h4D, 8'h00, {pc[1:0], pg[5:0]}, 16'h0, 16'hFFFF);
    cmd(8'h4D, 8'h00, 8'h43, 16'h0006, 16'hFFFF);
    cmd(8'h4D, 8'h00, 8'h43, 16'h0007, 16'hFFFF);
    cmd(8'h4D, 8'h00, 8'h42, 16'h0003, 16'hFFFF);
    cmd(8'h4D, 8'h00, 8'h46, 16'h0001, 16'hFFFF);
    cmd(8'h4D, 8'h00, 8'h00, 16'h0001, 16'hFFFF);
    cmd(8'h4D, 8'h00, 8'h45, 16'h0100, 16'hFFFF);
    cmd(8'h4D, 8'h00, 8'h45, 16'h0, 16'h000B);
    cmd(8'h4D, 8'h00, 8'h48, 16'h0, 16'h0000);
    cmd(8'h4D, 8'h01, 8'h43, 16'h0, 16'hFFFF);
    cmd(8'h4D, 8'h02, 8'h43, 16'h0, 16'hFFFF);
    cmd(8'h4C, 8'h00, 8'h43, 16'h0, 16'hFFFF);
    wb(1'b1, 8'h0C, 32'h0000_0002);
    foreach (cnt[a, b]) cnt[a][b] = 0;
    nmc = 0;
    hrc = 0;
    upd = 0;
    cmd(8'h4D, 8'h00, 8'h43, 16'h0, 16'hFFFF);
    slow <= 1'b0;
    events(100);
    wb(1'b1, 8'h0C, 32'h0000_8400);
    frz = 1;
    events(30);
    frz = 0;
    cmd(8'h4D, 8'h00, 8'h42, 16'h0, 16'hFFFF);
    cmd(8'h4D, 8'h00, 8'h48, 16'h0, 16'hFFFF);
    conclude();
  end
endmodule // tb
